// File: eix_cfg.svh
// Purpose: constants for the extended indexed instruction executor
// Assumes: 16-bit instruction words, 14-bit data addresses
// Notes:   offsets and opcodes are fixed by the core encoding
`ifndef EIX_CFG_SVH
`define EIX_CFG_SVH

`define EIX_OP_MOVE_HI       8'hEB
`define EIX_OP_PUSH_HI       8'hFA
`define EIX_OP_SUBRET_HI     8'hE9
`define EIX_OP_LONG_WORD     16'h0002
`define EIX_OP_FOLLOW_NIB    4'hF
`define EIX_OFFSET_LIMIT     8'h5F
`define EIX_ACCESS_HIGH_BASE 14'h3F00
`define EIX_PCL_ADDR         14'h3FF9
`define EIX_STACK_TOP_LOW_BYTE_ADDR        14'h3FFD
`define EIX_STACK_TOP_HIGH_BYTE_ADDR        14'h3FFE
`define EIX_STACK_TOP_UPPER_BYTE_ADDR        14'h3FFF
`define EIX_FP_RESET         14'h0000
`define EIX_ADDR_RESET       14'h0000
`define EIX_DATA_RESET       8'h00
`define EIX_PC_RESET         21'h00_0000

`endif

// File: eix_exec.sv
// Purpose: decode and execute of the extended indexed instructions
// Assumes: one instruction word per enabled cycle, memory reads return
//          data in the same cycle, return stack top is presented steady
// Notes:   standard instruction operand remap is a combinational path
`include "eix_cfg.svh"
`timescale 1ns/1ns
module eix_exec (
   // clock and reset
   input  wire logic         ref_clk_in,
   input  wire logic         nrst_in,
   // configuration
   input  wire logic         extension_enable_bit_in,
   input  wire logic [167:0] indirect_addr_list_in,
   // instruction stream
   input  wire logic         instr_valid_in,
   input  wire logic [15:0]  instr_word_in,
   // standard byte/bit operand translation
   input  wire logic [7:0]   std_operand_in,
   input  wire logic         std_access_sel_in,
   input  wire logic         std_dest_sel_in,
   input  wire logic [5:0]   bank_select_register_in,
   output logic [13:0]       std_addr_out,
   output logic              std_dest_is_file_out,
   // data memory
   output logic              mem_rd_out,
   output logic [13:0]       mem_rd_addr_out,
   input  wire logic [7:0]   mem_rd_data_in,
   output logic              mem_wr_out,
   output logic [13:0]       mem_wr_addr_out,
   output logic [7:0]        mem_wr_data_out,
   // return stack
   input  wire logic [20:0]  return_stack_top_in,
   output logic              pc_load_out,
   output logic [20:0]       pc_value_out,
   // status
   output logic [13:0]       frame_pointer_out,
   output logic              ext_busy_out
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   eix_pkg::eix_state_type state_reg, state_next;
   logic [13:0] fp_reg, fp_next;
   logic [7:0]  data_reg, data_next;
   logic [13:0] src_reg, src_next;
   logic        src_ind_reg, src_ind_next;
   logic        mem_wr_reg, mem_wr_next;
   logic [13:0] wr_addr_reg, wr_addr_next;
   logic [7:0]  wr_data_reg, wr_data_next;
   logic        pc_load_reg, pc_load_next;
   logic [20:0] pc_value_reg, pc_value_next;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire [7:0]  w_hi        = instr_word_in[15:8];
   wire [6:0]  w_off7      = instr_word_in[6:0];
   wire        en          = extension_enable_bit_in;
   wire        go          = instr_valid_in & en;
   wire        is_move_op  = (w_hi == `EIX_OP_MOVE_HI);
   wire        is_short    = go & is_move_op & ~instr_word_in[7];
   wire        is_frame    = go & is_move_op & instr_word_in[7];
   wire        is_long     = go & (instr_word_in == `EIX_OP_LONG_WORD);
   wire        is_push     = go & (w_hi == `EIX_OP_PUSH_HI);
   wire        is_subret   = go & (w_hi == `EIX_OP_SUBRET_HI)
                             & (instr_word_in[7:6] == 2'b11);
   wire        follow_ok   = (instr_word_in[15:12] == `EIX_OP_FOLLOW_NIB);

   wire [13:0] fp_plus_off = fp_reg + {7'b0, w_off7};
   // long move source offset lives in bits 8:2 of the second word
   wire [13:0] fp_plus_lng = fp_reg + {7'b0, instr_word_in[8:2]};
   // short destination: two top bank bits forced low, lower 4 Kbyte
   wire [13:0] short_dst   = {2'b00, instr_word_in[11:0]};
   // long destination: bits 13:12 were kept from the second word
   wire [13:0] long_dst    = {src_reg[1:0], instr_word_in[11:0]};

   wire        cand_src_ind;
   wire        cand_dst_ind;
   wire [13:0] cand_src    = (state_reg == eix_pkg::EIX_LONG_W2)
                             ? fp_plus_lng : fp_plus_off;
   eix_indirect_check u_src_chk (
      .addr_in     (cand_src),
      .ind_list_in (indirect_addr_list_in),
      .hit_out     (cand_src_ind)
   );
   eix_indirect_check u_dst_chk (
      .addr_in     (fp_plus_off),
      .ind_list_in (indirect_addr_list_in),
      .hit_out     (cand_dst_ind)
   );

   // protected destinations: pc low byte and the three stack top bytes
   wire        long_prot   = (long_dst == `EIX_PCL_ADDR)
                             | (long_dst == `EIX_STACK_TOP_LOW_BYTE_ADDR)
                             | (long_dst == `EIX_STACK_TOP_HIGH_BYTE_ADDR)
                             | (long_dst == `EIX_STACK_TOP_UPPER_BYTE_ADDR);
   wire        frame_prot  = (fp_plus_off == `EIX_PCL_ADDR)
                             | (fp_plus_off == `EIX_STACK_TOP_LOW_BYTE_ADDR)
                             | (fp_plus_off == `EIX_STACK_TOP_HIGH_BYTE_ADDR)
                             | (fp_plus_off == `EIX_STACK_TOP_UPPER_BYTE_ADDR);
   // indexed move writes only to a plain, unprotected register
   wire        frame_wr_ok = follow_ok & ~cand_dst_ind & ~frame_prot;

   // ---------------------------------------------------------------
   // standard operand translation
   // ---------------------------------------------------------------
   wire        low_access  = ~std_access_sel_in &
                             (std_operand_in <= `EIX_OFFSET_LIMIT);
   wire [13:0] idx_addr    = fp_reg + {6'b0, std_operand_in};
   // a zero pointer gives back the plain access ram location
   wire [13:0] acc_addr    = (std_operand_in <= `EIX_OFFSET_LIMIT)
                             ? {6'b0, std_operand_in}
                             : (`EIX_ACCESS_HIGH_BASE
                                | {6'b0, std_operand_in});
   wire [13:0] bank_addr   = {bank_select_register_in, std_operand_in};
   assign std_addr_out     = (en & low_access) ? idx_addr :
                             (std_access_sel_in ? bank_addr
                                                : acc_addr);
   assign std_dest_is_file_out = std_dest_sel_in;

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   logic        rd_now;
   logic [13:0] rd_addr_now;
   always_comb begin
      state_next    = state_reg;
      fp_next       = fp_reg;
      data_next     = data_reg;
      src_next      = src_reg;
      src_ind_next  = src_ind_reg;
      mem_wr_next   = 1'b0;
      wr_addr_next  = wr_addr_reg;
      wr_data_next  = wr_data_reg;
      pc_load_next  = 1'b0;
      pc_value_next = pc_value_reg;
      rd_now        = 1'b0;
      rd_addr_now   = `EIX_ADDR_RESET;
      case (state_reg)
         eix_pkg::EIX_FETCH: begin
            if (is_short | is_frame) begin
               // source read happens in the first cycle only
               rd_now       = 1'b1;
               rd_addr_now  = fp_plus_off;
               src_ind_next = cand_src_ind;
               data_next    = mem_rd_data_in;
               state_next   = is_short ? eix_pkg::EIX_SHORT_W2
                                       : eix_pkg::EIX_FRAME_W2;
            end else if (is_long) begin
               state_next = eix_pkg::EIX_LONG_W2;
            end else if (is_push) begin
               mem_wr_next  = 1'b1;
               wr_addr_next = fp_reg;
               wr_data_next = instr_word_in[7:0];
               fp_next      = fp_reg - 14'h0001;
            end else if (is_subret) begin
               fp_next       = fp_reg - {8'b0, instr_word_in[5:0]};
               pc_load_next  = 1'b1;
               pc_value_next = return_stack_top_in;
               state_next    = eix_pkg::EIX_RET_NOP;
            end else if (instr_valid_in & follow_ok) begin
               // orphaned follow-on word: consumed with no effect
               state_next    = eix_pkg::EIX_FETCH;
            end
         end
         eix_pkg::EIX_SHORT_W2: begin
            if (instr_valid_in) begin
               if (follow_ok) begin
                  mem_wr_next  = 1'b1;
                  wr_addr_next = short_dst;
                  wr_data_next = src_ind_reg ? `EIX_DATA_RESET
                                             : data_reg;
               end
               state_next = eix_pkg::EIX_FETCH;
            end
         end
         eix_pkg::EIX_LONG_W2: begin
            if (instr_valid_in) begin
               rd_now       = follow_ok;
               rd_addr_now  = fp_plus_lng;
               src_ind_next = cand_src_ind;
               data_next    = mem_rd_data_in;
               // keep destination bits 13:12 for the third word
               src_next     = {2'b00, 10'b0, instr_word_in[1:0]};
               state_next   = follow_ok ? eix_pkg::EIX_LONG_W3
                                        : eix_pkg::EIX_FETCH;
            end
         end
         eix_pkg::EIX_LONG_W3: begin
            if (instr_valid_in) begin
               if (follow_ok && !long_prot) begin
                  mem_wr_next  = 1'b1;
                  wr_addr_next = long_dst;
                  wr_data_next = src_ind_reg ? `EIX_DATA_RESET
                                             : data_reg;
               end
               state_next = eix_pkg::EIX_FETCH;
            end
         end
         eix_pkg::EIX_FRAME_W2: begin
            if (instr_valid_in) begin
               // indirect or protected destination: no write at all
               if (frame_wr_ok) begin
                  mem_wr_next  = 1'b1;
                  wr_addr_next = fp_plus_off;
                  wr_data_next = src_ind_reg ? `EIX_DATA_RESET
                                             : data_reg;
               end
               state_next = eix_pkg::EIX_FETCH;
            end
         end
         eix_pkg::EIX_RET_NOP: begin
            if (instr_valid_in) begin
               state_next = eix_pkg::EIX_FETCH;
            end
         end
         default: begin
            state_next = eix_pkg::EIX_FETCH;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registers: sequencer state
   // ---------------------------------------------------------------
   // a reset mid-instruction drops any half-taken move
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         state_reg <= eix_pkg::EIX_FETCH;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // registers: frame pointer
   // ---------------------------------------------------------------
   // wraps at 14 bits, as the data space does
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         fp_reg <= `EIX_FP_RESET;
      end else begin
         fp_reg <= fp_next;
      end
   end

   // ---------------------------------------------------------------
   // registers: captured source
   // ---------------------------------------------------------------
   // source byte is caught once, so no dummy read is needed later
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         data_reg <= `EIX_DATA_RESET;
      end else begin
         data_reg <= data_next;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         src_reg <= `EIX_ADDR_RESET;
      end else begin
         src_reg <= src_next;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         src_ind_reg <= 1'b0;
      end else begin
         src_ind_reg <= src_ind_next;
      end
   end

   // ---------------------------------------------------------------
   // registers: write port
   // ---------------------------------------------------------------
   // strobe is a one-cycle pulse; address and data hold until reuse
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         mem_wr_reg <= 1'b0;
      end else begin
         mem_wr_reg <= mem_wr_next;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         wr_addr_reg <= `EIX_ADDR_RESET;
      end else begin
         wr_addr_reg <= wr_addr_next;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         wr_data_reg <= `EIX_DATA_RESET;
      end else begin
         wr_data_reg <= wr_data_next;
      end
   end

   // ---------------------------------------------------------------
   // registers: return
   // ---------------------------------------------------------------
   // stack top is sampled with the opcode, not in the idle cycle
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         pc_load_reg <= 1'b0;
      end else begin
         pc_load_reg <= pc_load_next;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         pc_value_reg <= `EIX_PC_RESET;
      end else begin
         pc_value_reg <= pc_value_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // read strobe is combinational: the memory answers in the same cycle
   assign mem_rd_out        = rd_now;
   assign mem_rd_addr_out   = rd_addr_now;
   assign mem_wr_out        = mem_wr_reg;
   assign mem_wr_addr_out   = wr_addr_reg;
   assign mem_wr_data_out   = wr_data_reg;
   assign pc_load_out       = pc_load_reg;
   assign pc_value_out      = pc_value_reg;
   assign frame_pointer_out = fp_reg;
   assign ext_busy_out      = (state_reg != eix_pkg::EIX_FETCH);
endmodule : eix_exec

// File: eix_exec_asserts.sv
// Purpose: port-level checks of the extended instruction executor
// Assumes: a first word is taken only while ext_busy_out is low
// Notes:   bound in from the testbench top
`include "eix_cfg.svh"
`timescale 1ns/1ns
module eix_exec_asserts (
   // clock and reset
   input wire logic        ref_clk_in,
   input wire logic        nrst_in,
   // inputs watched
   input wire logic        extension_enable_bit_in,
   input wire logic        instr_valid_in,
   input wire logic [15:0] instr_word_in,
   input wire logic [7:0]  std_operand_in,
   input wire logic        std_access_sel_in,
   input wire logic        std_dest_sel_in,
   input wire logic [5:0]  bank_select_register_in,
   input wire logic [20:0] return_stack_top_in,
   // outputs watched
   input wire logic [13:0] std_addr_out,
   input wire logic        std_dest_is_file_out,
   input wire logic        mem_rd_out,
   input wire logic [13:0] mem_rd_addr_out,
   input wire logic        mem_wr_out,
   input wire logic [13:0] mem_wr_addr_out,
   input wire logic [7:0]  mem_wr_data_out,
   input wire logic        pc_load_out,
   input wire logic [20:0] pc_value_out,
   input wire logic [13:0] frame_pointer_out,
   input wire logic        ext_busy_out
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   logic        take;
   logic        low_op;
   logic [13:0] op_ext;
   logic        is_ret;
   assign take   = instr_valid_in && extension_enable_bit_in && !ext_busy_out;
   assign low_op = std_operand_in <= `EIX_OFFSET_LIMIT;
   assign op_ext = {6'h00, std_operand_in};
   assign is_ret = take && instr_word_in[15:6] == {`EIX_OP_SUBRET_HI, 2'b11};
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_push;
      take && instr_word_in[15:8] == `EIX_OP_PUSH_HI;
   endsequence
   sequence s_idx;
      take && instr_word_in[15:7] == {`EIX_OP_MOVE_HI, 1'b1} ##1
      instr_valid_in && instr_word_in[15:12] == `EIX_OP_FOLLOW_NIB;
   endsequence
   chk_push_write: assert property (
      s_push |=> mem_wr_out && mem_wr_addr_out == $past(frame_pointer_out)
      && mem_wr_data_out == $past(instr_word_in[7:0]))
      else $error("push wrote wrong place or value");
   chk_push_fp: assert property (
      s_push |=> frame_pointer_out == $past(frame_pointer_out) - 14'h0001)
      else $error("push did not step the pointer down");
   chk_subret_pc: assert property (
      is_ret |=> pc_load_out && pc_value_out == $past(return_stack_top_in)
      && frame_pointer_out == $past(frame_pointer_out)
      - {8'h00, $past(instr_word_in[5:0])})
      else $error("return load or pointer wrong");
   chk_subret_nop: assert property (
      is_ret |=> ext_busy_out ##1 !pc_load_out)
      else $error("return second cycle not idle");
   chk_ext_off: assert property (
      !extension_enable_bit_in [*3] |-> !mem_wr_out && !pc_load_out)
      else $error("extension acted while disabled");
   chk_std_remap: assert property (
      extension_enable_bit_in && !std_access_sel_in && low_op
      |-> std_addr_out == frame_pointer_out + op_ext)
      else $error("low operand not pointer relative");
   chk_std_plain: assert property (
      !extension_enable_bit_in |-> std_addr_out == (std_access_sel_in ?
      {bank_select_register_in, std_operand_in} : low_op ? op_ext :
      (`EIX_ACCESS_HIGH_BASE | op_ext)))
      else $error("plain operand address wrong");
   chk_dest_sel: assert property (
      std_dest_is_file_out == std_dest_sel_in)
      else $error("destination select altered");
   chk_short_read: assert property (
      take && instr_word_in[15:7] == {`EIX_OP_MOVE_HI, 1'b0} |-> mem_rd_out
      && mem_rd_addr_out == frame_pointer_out + {7'h00, instr_word_in[6:0]}
      ##1 !mem_rd_out)
      else $error("short move source read wrong");
   chk_idx_dest: assert property (
      s_idx |=> !mem_wr_out || mem_wr_addr_out ==
      frame_pointer_out + {7'h00, $past(instr_word_in[6:0])})
      else $error("indexed move wrote wrong place");
endmodule : eix_exec_asserts

// File: eix_exec_tb_top.sv
// Purpose: self-checking bench of the extended instruction executor
// Assumes: pointer starts at zero and is moved by push and return only
// Notes:   write and return pulses are counted by a monitor
`timescale 1ns/1ns
module eix_exec_tb_top;
   logic ref_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic ext_en = 1'b0;
   logic valid = 1'b0;
   logic [15:0] word = 16'h0000;
   logic [7:0] opnd = 8'h00;
   logic acc = 1'b0;
   logic dsel = 1'b0;
   wire logic [13:0] std_a, rd_a, wr_addr, fp;
   wire logic [7:0] rd_d, wr_data;
   wire logic [20:0] top, pc_val;
   wire logic dfile, rd, wr, pc_ld, busy;
   int failures = 0;
   int checks = 0;
   int wr_cnt = 0;
   int pc_cnt = 0;
   logic [13:0] wr_a = 14'h0000;
   logic [7:0] wr_d = 8'h00;
   always #5 ref_clk_in = ~ref_clk_in;
   eix_exec u_dut (.ref_clk_in, .nrst_in, .extension_enable_bit_in(ext_en),
      .indirect_addr_list_in({14'h3FEF, 14'h3FE7, {10{14'h3FDF}}}),
      .instr_valid_in(valid), .instr_word_in(word), .std_operand_in(opnd),
      .std_access_sel_in(acc), .std_dest_sel_in(dsel),
      .bank_select_register_in(6'h05), .std_addr_out(std_a),
      .std_dest_is_file_out(dfile), .mem_rd_out(rd), .mem_rd_addr_out(rd_a),
      .mem_rd_data_in(rd_d), .mem_wr_out(wr), .mem_wr_addr_out(wr_addr),
      .mem_wr_data_out(wr_data), .return_stack_top_in(top),
      .pc_load_out(pc_ld), .pc_value_out(pc_val), .frame_pointer_out(fp),
      .ext_busy_out(busy));
   eix_mem_model u_mem (.ref_clk_in, .mem_rd_in(rd), .mem_rd_addr_in(rd_a),
      .mem_rd_data_out(rd_d), .mem_wr_in(wr), .mem_wr_addr_in(wr_addr),
      .mem_wr_data_in(wr_data), .return_stack_top_out(top));
   always @(posedge ref_clk_in) begin
      if (wr === 1'b1) begin
         wr_cnt++;
         wr_a = wr_addr;
         wr_d = wr_data;
      end
      if (pc_ld === 1'b1) pc_cnt++;
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : cmp
   task automatic run(input logic [15:0] w [$]);
      wr_cnt = 0;
      pc_cnt = 0;
      foreach (w[i]) begin
         @(posedge ref_clk_in);
         valid <= 1'b1;
         word <= w[i];
      end
      @(posedge ref_clk_in);
      valid <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      #1;
   endtask : run
   task automatic std(input logic [7:0] op, input logic a);
      @(posedge ref_clk_in);
      opnd <= op;
      acc <= a;
      #1;
   endtask : std
   task automatic end_sim;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_off;
      run({16'hFA3C});
      cmp(wr_cnt, 0);
      std(8'h10, 1'b0); cmp(std_a, 14'h0010);
      std(8'h80, 1'b0); cmp(std_a, 14'h3F80);
      std(8'h80, 1'b1); cmp(std_a, 14'h0580);
   endtask : t_off
   task automatic t_push_ret;
      std(8'h10, 1'b0); cmp(std_a, 14'h0010);
      @(posedge ref_clk_in);
      dsel <= 1'b1;
      #1 cmp(dfile, 1'b1);
      run({16'hFA3C});
      cmp(wr_cnt, 1);
      cmp({wr_a, wr_d}, {14'h0000, 8'h3C});
      cmp(fp, 14'h3FFF);
      run({16'hE9DE, 16'h0000});
      cmp(pc_cnt, 1);
      cmp(pc_val, 21'h0A_BCDE);
      cmp(fp, 14'h3FE1);
      std(8'h5F, 1'b0); cmp(std_a, 14'h0040);
      std(8'h60, 1'b0); cmp(std_a, 14'h3F60);
   endtask : t_push_ret
   task automatic t_moves;
      run({16'hEB05, 16'hF123});
      cmp(wr_cnt, 1);
      cmp({wr_a, wr_d}, {14'h0123, 8'h43});
      run({16'hF123});
      cmp(wr_cnt, 0);
      run({16'h0002, 16'hF043, 16'hF456});
      cmp({wr_cnt[7:0], wr_a, wr_d}, {8'h01, 14'h3456, 8'h54});
      run({16'h0002, 16'hF043, 16'hFFF9});
      cmp(wr_cnt, 0);
      run({16'hEB82, 16'hF004});
      cmp({wr_cnt[7:0], wr_a, wr_d}, {8'h01, 14'h3FE5, 8'h46});
      run({16'hEB8E, 16'hF005});
      cmp({wr_cnt[7:0], wr_d}, {8'h01, 8'h00});
      run({16'hEB82, 16'hF006});
      cmp(wr_cnt, 0);
      run({16'hEB82, 16'hF018});
      cmp(wr_cnt, 0);
   endtask : t_moves
   initial begin
      repeat (4) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      @(posedge ref_clk_in);
      #1 cmp({fp, wr, pc_ld}, 16'h0000);
      t_off();
      @(posedge ref_clk_in);
      ext_en <= 1'b1;
      t_push_ret();
      t_moves();
      end_sim();
   end
   initial begin
      repeat (2000) @(posedge ref_clk_in);
      failures++;
      end_sim();
   end
endmodule : eix_exec_tb_top
bind eix_exec eix_exec_asserts u_chk (.ref_clk_in, .nrst_in,
   .extension_enable_bit_in, .instr_valid_in, .instr_word_in,
   .std_operand_in, .std_access_sel_in, .std_dest_sel_in,
   .bank_select_register_in, .return_stack_top_in, .std_addr_out,
   .std_dest_is_file_out, .mem_rd_out, .mem_rd_addr_out, .mem_wr_out,
   .mem_wr_addr_out, .mem_wr_data_out, .pc_load_out, .pc_value_out,
   .frame_pointer_out, .ext_busy_out);

// File: eix_indirect_check.sv
// Purpose: flags addresses that name an indirect addressing register
// Assumes: caller supplies the set of indirect register addresses
// Notes:   one compare per register, built by a generate loop
`timescale 1ns/1ns
module eix_indirect_check (
   // address under test
   input  wire logic [13:0]   addr_in,
   // indirect register address list, flattened
   input  wire logic [167:0]  ind_list_in,
   // result
   output logic               hit_out
);
   wire [11:0] match_vec;
   genvar i;
   generate
      for (i = 0; i < 12; i = i + 1) begin : g_cmp
         assign match_vec[i] = (ind_list_in[i*14 +: 14] == addr_in);
      end
   endgenerate
   assign hit_out = |match_vec;
endmodule : eix_indirect_check

// File: eix_mem_model.sv
// Purpose: data memory and return stack beside the executor
// Assumes: reads answer in the same cycle, writes land on the edge
// Notes:   unwritten bytes hold a pattern derived from their address
`timescale 1ns/1ns
module eix_mem_model (
   // clock
   input  wire logic        ref_clk_in,
   // read port
   input  wire logic        mem_rd_in,
   input  wire logic [13:0] mem_rd_addr_in,
   output logic [7:0]       mem_rd_data_out,
   // write port
   input  wire logic        mem_wr_in,
   input  wire logic [13:0] mem_wr_addr_in,
   input  wire logic [7:0]  mem_wr_data_in,
   // return stack
   output logic [20:0]      return_stack_top_out
);
   logic [7:0] mem_reg [0:16383];
   logic [7:0] last_reg = 8'h00;
   initial for (int i = 0; i < 16384; i++) mem_reg[i] = 8'(i) ^ 8'hA5;
   assign return_stack_top_out = 21'h0A_BCDE;
   // an idle read port shows no stale data, so a late sample is caught
   assign mem_rd_data_out = mem_rd_in ? mem_reg[mem_rd_addr_in] : ~last_reg;
   always @(posedge ref_clk_in) begin
      if (mem_rd_in) last_reg <= mem_reg[mem_rd_addr_in];
      if (mem_wr_in) mem_reg[mem_wr_addr_in] <= mem_wr_data_in;
   end
endmodule : eix_mem_model

// File: eix_pkg.sv
// Purpose: types for the extended indexed instruction executor
// Assumes: constants live in eix_cfg.svh
// Notes:   none
package eix_pkg;
   typedef enum logic [2:0] {
      EIX_FETCH    = 3'b000,
      EIX_SHORT_W2 = 3'b001,
      EIX_LONG_W2  = 3'b010,
      EIX_LONG_W3  = 3'b011,
      EIX_FRAME_W2 = 3'b100,
      EIX_RET_NOP  = 3'b101
   } eix_state_type;
endpackage : eix_pkg
